// ### rtl/scp_pkg.sv
// Purpose: constants and types for the spike class count packer
// Assumes: 16 input channels, codes 1..2 counted, counters of one to eight bits, five after reset
// Notes:   register offsets are byte addresses on an AXI4-Lite slave
// Operation
// RULE_01: count each code on each channel between two consecutive strobes.
// RULE_02: on a strobe latch every counter as output and clear all counters; packed fields past bit 127 are dropped from the output.
// RULE_03: the strobe comes from an internal period timer or an external input.
// RULE_04: codes per channel and counter width are configurable settings.
// RULE_05: latched counts pack into 32-bit words, fields from the low bits up.
// RULE_06: with two codes of four bits each word holds four channels, code 1 low.
// RULE_07: an n-bit field counts from zero to two to the n minus one.
// RULE_08: the packed counts leave as a stream of words, one lane per word.
// RULE_09: each binning event raises a one-cycle pulse on the strobe output.
// RULE_10: with storage on, each strobe records the packed counts with a time.
// RULE_11: a counter at its top value holds there until the interval ends.
// RULE_12: upstream gives per channel per clock either zero or a nonzero code.
package scp_pkg;
    // ======================================================
    // geometry
    localparam int NCH    = 16;
    localparam int CODE_W = 2;
    localparam int CNT_W  = 4;
    localparam int NWORD  = 4;
    localparam int TS_W   = 32;
    // ======================================================
    // register map
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_PERIOD = 8'h04;
    localparam logic [7:0] OFS_STAT   = 8'h08;
    localparam logic [7:0] OFS_TSTAMP = 8'h0c;
    localparam logic [7:0] OFS_WORD0  = 8'h10;
    localparam logic [7:0] OFS_LAST   = 8'h1c;
    // ctrl field positions
    localparam int CTRL_EXT_BIT   = 0;
    localparam int CTRL_STORE_BIT = 1;
    localparam int CTRL_TWO_BIT   = 2;
    localparam int CTRL_BITS_LSB  = 4;
    // reset values
    localparam logic [31:0] CTRL_RST   = 32'h0000_0044;
    localparam logic [31:0] PERIOD_RST = 32'h0000_9c40;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [31:0] period;
        logic [2:0]  bits_m1;
        logic        two_codes;
        logic        store_en;
        logic        ext_sel;
    } scp_cfg_type;

    typedef struct packed {
        logic [NWORD*32-1:0] words;
        logic [TS_W-1:0]     stamp;
    } scp_record_type;
endpackage : scp_pkg

// ### rtl/scp_top.sv
// Purpose: per-channel spike code counter with strobe latch and packing
// Assumes: one clock mclk_i at 40 MHz, AXI4-Lite register access
// Notes:   fields packed from bit 0 upward; field width set by software
//
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module scp_top
    import scp_pkg::*;
(
    // clock and reset
    input  wire logic                          mclk_i,
    input  wire logic                          rst_i,
    // spike codes and external strobe
    input  wire logic [scp_pkg::NCH*scp_pkg::CODE_W-1:0] code_i,
    input  wire logic                          ext_strobe_i,
    // packed stream
    output logic [scp_pkg::NWORD*32-1:0]       main_words_o,
    output logic                               main_valid_o,
    output logic                               bin_event_pulse_o,
    // axi4-lite write
    input  wire logic [7:0]                    s_awaddr_i,
    input  wire logic                          s_awvalid_i,
    output logic                               s_awready_o,
    input  wire logic [31:0]                   s_wdata_i,
    input  wire logic [3:0]                    s_wstrb_i,
    input  wire logic                          s_wvalid_i,
    output logic                               s_wready_o,
    output logic [1:0]                         s_bresp_o,
    output logic                               s_bvalid_o,
    input  wire logic                          s_bready_i,
    // axi4-lite read
    input  wire logic [7:0]                    s_araddr_i,
    input  wire logic                          s_arvalid_i,
    output logic                               s_arready_o,
    output logic [31:0]                        s_rdata_o,
    output logic [1:0]                         s_rresp_o,
    output logic                               s_rvalid_o,
    input  wire logic                          s_rready_i
);
    import scp_pkg::*;

    // ======================================================
    // functions
    // saturating add: a full counter stays full
    function automatic logic [7:0] sat_inc(input logic [7:0] c,
                                           input logic [7:0] top);
        sat_inc = (c >= top) ? top : c + 8'h01;
    endfunction : sat_inc

    // pack latched counts, fields from the low bits upward
    function automatic logic [NWORD*32-1:0] pack(
        input logic [2*NCH*8-1:0] cnt,
        input scp_cfg_type        cfg);
        logic [NWORD*32-1:0] w;
        int                  pos;
        int                  fw;
        w   = '0;
        pos = 0;
        fw  = int'(cfg.bits_m1) + 1;
        for (int ch = 0; ch < NCH; ch++)
        begin
            for (int k = 0; k < 2; k++)
            begin
                if (k == 0 || cfg.two_codes)
                begin
                    for (int b = 0; b < 8; b++)
                    begin
                        if (b < fw && pos + b < NWORD*32)
                            w[pos + b] = cnt[(ch*2 + k)*8 + b];
                    end
                    pos = pos + fw;
                end
            end
        end
        pack = w;
    endfunction : pack

    // ======================================================
    // state
    scp_cfg_type            cfg_q;
    logic [2*NCH*8-1:0]     cnt_q;
    logic [31:0]            tmr_q;
    logic [TS_W-1:0]        time_q;
    scp_record_type         rec_q;
    logic                   ext_s1_q;
    logic                   ext_s2_q;
    logic                   ext_s3_q;
    logic                   strobe;
    logic [7:0]             top;

    // external strobe passes two flops, then edge detect
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end
        else
        begin
            ext_s1_q <= ext_strobe_i;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // period timer; counting restarts at each of its own strobes
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            tmr_q <= 32'h0000_0000;
        else if (cfg_q.ext_sel || tmr_q + 32'h1 >= cfg_q.period)
            tmr_q <= 32'h0000_0000;
        else
            tmr_q <= tmr_q + 32'h1;
    end

    // source select [RULE_03]
    assign strobe = cfg_q.ext_sel ? (ext_s2_q & ~ext_s3_q)
                                  : (tmr_q + 32'h1 >= cfg_q.period);
    // field top value 2^n-1 [RULE_07] [RULE_04]
    assign top = 8'((9'h002 << cfg_q.bits_m1) - 9'h001);

    // counters: bump by code, clear on strobe [RULE_01] [RULE_02]
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            cnt_q <= '0;
        else
        begin
            for (int ch = 0; ch < NCH; ch++)
            begin
                for (int k = 0; k < 2; k++)
                begin
                    if (strobe)
                        cnt_q[(ch*2+k)*8 +: 8] <= 8'h00;
                    else if (code_i[ch*CODE_W +: CODE_W] == CODE_W'(k+1)) // [RULE_12]
                        cnt_q[(ch*2+k)*8 +: 8] <=
                            sat_inc(cnt_q[(ch*2+k)*8 +: 8], top); // [RULE_11]
                end
            end
        end
    end
    // note: an event in the strobe cycle is dropped with the old interval

    // free time base used to stamp stored records
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            time_q <= '0;
        else
            time_q <= time_q + TS_W'(1);
    end

    // latch and pack [RULE_02] [RULE_05] [RULE_06] [RULE_08] [RULE_09]
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            main_words_o      <= '0;
            main_valid_o      <= 1'b0;
            bin_event_pulse_o <= 1'b0;
        end
        else
        begin
            main_valid_o      <= strobe;
            bin_event_pulse_o <= strobe;
            if (strobe)
                main_words_o <= pack(cnt_q, cfg_q);
        end
    end

    // timestamped record when storage is on [RULE_10]
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
            rec_q <= '0;
        else if (strobe && cfg_q.store_en)
        begin
            rec_q.words <= pack(cnt_q, cfg_q);
            rec_q.stamp <= time_q;
        end
    end

    // ======================================================
    // axi4-lite write channel
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_q;
    logic [31:0] wd_q;

    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            aw_q       <= 8'h00;
            wd_q       <= 32'h0;
            s_bvalid_o <= 1'b0;
            s_bresp_o  <= RESP_OKAY;
            // fields picked by position so bit 3 of the reset word is skipped
            cfg_q.period    <= PERIOD_RST;
            cfg_q.bits_m1   <= CTRL_RST[CTRL_BITS_LSB +: 3];
            cfg_q.two_codes <= CTRL_RST[CTRL_TWO_BIT];
            cfg_q.store_en  <= CTRL_RST[CTRL_STORE_BIT];
            cfg_q.ext_sel   <= CTRL_RST[CTRL_EXT_BIT];
        end
        else
        begin
            if (s_awvalid_i && s_awready_o)
            begin
                aw_have_q <= 1'b1;
                aw_q      <= s_awaddr_i;
            end
            if (s_wvalid_i && s_wready_o)
            begin
                w_have_q <= 1'b1;
                wd_q     <= s_wdata_i;
            end
            if (aw_have_q && w_have_q && !s_bvalid_o)
            begin
                aw_have_q  <= 1'b0;
                w_have_q   <= 1'b0;
                s_bvalid_o <= 1'b1;
                s_bresp_o  <= RESP_OKAY;
                if (aw_q[7:2] == OFS_CTRL[7:2])
                begin
                    cfg_q.ext_sel   <= wd_q[CTRL_EXT_BIT];
                    cfg_q.store_en  <= wd_q[CTRL_STORE_BIT];
                    cfg_q.two_codes <= wd_q[CTRL_TWO_BIT];
                    cfg_q.bits_m1   <= wd_q[CTRL_BITS_LSB +: 3];
                end
                else if (aw_q[7:2] == OFS_PERIOD[7:2])
                    cfg_q.period <= (wd_q == 32'h0) ? 32'h1 : wd_q;
                else
                    s_bresp_o <= RESP_SLVERR;
            end
            else if (s_bvalid_o && s_bready_i)
                s_bvalid_o <= 1'b0;
        end
    end
    assign s_awready_o = !aw_have_q && !s_bvalid_o;
    assign s_wready_o  = !w_have_q && !s_bvalid_o;

    // ======================================================
    // axi4-lite read channel, one cycle after address
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            s_rvalid_o <= 1'b0;
            s_rdata_o  <= 32'h0;
            s_rresp_o  <= RESP_OKAY;
        end
        else if (s_arvalid_i && s_arready_o)
        begin
            s_rvalid_o <= 1'b1;
            s_rresp_o  <= RESP_OKAY;
            s_rdata_o  <= 32'h0;
            if (s_araddr_i[7:2] == OFS_CTRL[7:2])
                s_rdata_o <= {25'h0, cfg_q.bits_m1, 1'b0, cfg_q.two_codes,
                              cfg_q.store_en, cfg_q.ext_sel};
            else if (s_araddr_i[7:2] == OFS_PERIOD[7:2])
                s_rdata_o <= cfg_q.period;
            else if (s_araddr_i[7:2] == OFS_STAT[7:2])
                s_rdata_o <= tmr_q;
            else if (s_araddr_i[7:2] == OFS_TSTAMP[7:2])
                s_rdata_o <= rec_q.stamp;
            else if (s_araddr_i[7:2] >= OFS_WORD0[7:2] &&
                     s_araddr_i[7:2] <= OFS_LAST[7:2])
                s_rdata_o <= rec_q.words[32*s_araddr_i[3:2] +: 32];
            else
                s_rresp_o <= RESP_SLVERR;
        end
        else if (s_rvalid_o && s_rready_i)
            s_rvalid_o <= 1'b0;
    end
    assign s_arready_o = !s_rvalid_o;

    // ======================================================
    // checks
    a_pulse_width: assert property (@(posedge mclk_i) disable iff (rst_i)
        bin_event_pulse_o |=> !bin_event_pulse_o || $past(strobe))
        else $error("pulse without strobe"); // [RULE_09]
    a_clear_strobe: assert property (@(posedge mclk_i) disable iff (rst_i)
        strobe |=> cnt_q == '0)
        else $error("counters not cleared"); // [RULE_02]
    a_pulse_cause: assert property (@(posedge mclk_i) disable iff (rst_i)
        strobe |=> bin_event_pulse_o && main_valid_o)
        else $error("strobe not signalled"); // [RULE_09]
    a_latch_value: assert property (@(posedge mclk_i) disable iff (rst_i)
        strobe |=> main_words_o == pack($past(cnt_q), $past(cfg_q)))
        else $error("latch mismatch"); // [RULE_02]
    a_sat_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        !strobe && cnt_q[7:0] == top |=> cnt_q[7:0] == $past(top) ||
        $past(cfg_q.bits_m1) != cfg_q.bits_m1)
        else $error("counter wrapped"); // [RULE_11]
    a_cnt_bound: assert property (@(posedge mclk_i) disable iff (rst_i)
        !strobe && code_i[1:0] == 2'h1 && cnt_q[7:0] < top
        |=> cnt_q[7:0] == $past(cnt_q[7:0]) + 8'h01)
        else $error("count missed"); // [RULE_01]
    a_timer_src: assert property (@(posedge mclk_i) disable iff (rst_i)
        !cfg_q.ext_sel && tmr_q + 32'h1 >= cfg_q.period |-> strobe)
        else $error("timer strobe lost"); // [RULE_03]
    a_store_rec: assert property (@(posedge mclk_i) disable iff (rst_i)
        strobe && cfg_q.store_en |=> rec_q.stamp == $past(time_q))
        else $error("record not stamped"); // [RULE_10]
    a_word_pack: assert property (@(posedge mclk_i) disable iff (rst_i)
        strobe && cfg_q.bits_m1 == 3'h3 && cfg_q.two_codes
        |=> main_words_o[35:32] == $past(cnt_q[67:64]))
        else $error("word two misplaced"); // [RULE_06]
endmodule : scp_top

// ### tb/scp_src_model.sv
// Purpose: upstream spike code source and strobe source model
// Assumes: codes are levels taken on each rise of mclk_i
// Notes:   outside a burst every channel carries code 0, no event
`timescale 1ns/1ps
module scp_src_model
(
    // clock
    input  wire logic                               mclk_i,
    // codes and external strobe toward the packer
    output logic [scp_pkg::NCH*scp_pkg::CODE_W-1:0] code_o,
    output logic                                    ext_strobe_o
);
    // =====================================================
    // idle levels: no event, strobe low
    initial
    begin
        code_o       = '0;
        ext_strobe_o = 1'b0;
    end

    // cycle c: 1 while c<a, 2 while c<a+b, then 3 (a nonzero ignored code)
    task automatic burst(input int a[16], input int b[16], input int len);
        for (int c = 0; c < len; c++)
        begin
            @(posedge mclk_i);
            for (int n = 0; n < 16; n++)
                code_o[2*n +: 2] <= (c < a[n]) ? 2'h1 :
                    ((c < a[n] + b[n]) ? 2'h2 : 2'h3);
        end
        @(posedge mclk_i);
        code_o <= '0;
    endtask : burst

    // held three cycles so the two-flop sync cannot miss it
    task automatic strobe();
        @(posedge mclk_i);
        ext_strobe_o <= 1'b1;
        repeat (3) @(posedge mclk_i);
        ext_strobe_o <= 1'b0;
    endtask : strobe
endmodule : scp_src_model

// ### tb/test_spike_class_count_packer.sv
// Purpose: self-checking bench for the spike class count packer
// Assumes: ext strobe mode for exact intervals, small timer period
// Notes:   expected packing is rebuilt here from the stimulus counts
`timescale 1ns/1ps
module test_spike_class_count_packer;
    import scp_pkg::*;
    // =====================================================
    // signals
    logic         mclk_i = 1'b0;
    logic         rst_i  = 1'b1;
    wire  [31:0]  code;
    wire          ext_stb;
    logic [127:0] words;
    logic         valid, pulse, awready, wready, bvalid, arready, rvalid;
    logic [1:0]   bresp, rresp, r;
    logic [31:0]  rdata;
    logic [31:0]  wdata = 32'h0;
    logic [7:0]   awaddr = 8'h0;
    logic [7:0]   araddr = 8'h0;
    logic         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic         arvalid = 1'b0, rready = 1'b0;
    int           n_mismatch = 0, checked = 0, n;
    int           na[16], nb[16];
    logic [127:0] ex;
    logic [31:0]  ctl;

    // =====================================================
    // design and source model
    scp_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .code_i(code),
        .ext_strobe_i(ext_stb), .main_words_o(words), .main_valid_o(valid),
        .bin_event_pulse_o(pulse), .s_awaddr_i(awaddr),
        .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata),
        .s_wstrb_i(4'hf), .s_wvalid_i(wvalid), .s_wready_o(wready),
        .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
        .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
        .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
        .s_rready_i(rready));
    scp_src_model src (.mclk_i(mclk_i), .code_o(code),
        .ext_strobe_o(ext_stb));

    // 25 ns period
    initial
    begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    // =====================================================
    // verdict and comparison
    task automatic conclude();
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [127:0] got, ex_v);
        checked++;
        if (got !== ex_v)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex_v, got);
        end
    endtask : chk

    task automatic tmo();
        n_mismatch++;
        conclude();
    endtask : tmo

    // =====================================================
    // axi4-lite master: hold each channel until its own ready
    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] rs);
        @(posedge mclk_i);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int i = 0; i <= 50; i++)
        begin
            if (i == 50)
                tmo();
            @(posedge mclk_i);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid)
            begin
                rs = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : axw

    task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        @(posedge mclk_i);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int i = 0; i <= 50; i++)
        begin
            if (i == 50)
                tmo();
            @(posedge mclk_i);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid)
            begin
                chk("rdata", 128'(rdata), 128'(ed));
                chk("rresp", 128'(rresp), 128'(er));
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd

    // n counts edges until the pulse is seen; bounded
    task automatic wait_pulse(output int k);
        for (k = 1; k <= 400; k++)
        begin
            @(posedge mclk_i);
            if (pulse === 1'b1)
                break;
        end
        if (k > 400)
            tmo();
    endtask : wait_pulse

    // fields of w bits from bit 0 up, ch order, code 1 below code 2
    function automatic logic [127:0] pack(input bit two, input int w);
        logic [127:0] v;
        int           idx, c;
        v = '0;
        for (int ch = 0; ch < 16; ch++)
            for (int k = 0; k < (two ? 2 : 1); k++)
            begin
                idx = (ch * (two ? 2 : 1) + k) * w;
                c = (k == 0) ? na[ch] : nb[ch];
                if (c > (1 << w) - 1)
                    c = (1 << w) - 1;
                for (int b = 0; b < w; b++)
                    if (idx + b < 128 && idx + w <= 128)
                        v[idx + b] = c[b];
            end
        return v;
    endfunction : pack

    // =====================================================
    // main sequence
    initial
    begin
        for (int ch = 0; ch < 16; ch++)
        begin
            na[ch] = (ch == 0) ? 20 : ch;
            nb[ch] = (ch * 3) % 5;
        end
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(OFS_CTRL, CTRL_RST, RESP_OKAY);
        rd(OFS_PERIOD, PERIOD_RST, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        axw(8'h40, 32'h1, r);
        chk("bad write resp", 128'(r), 128'(RESP_SLVERR));
        // configs: two codes 4 bits, one code 3 bits, two codes 8 bits
        for (int i = 0; i < 3; i++)
        begin
            ctl = (i == 1) ? 32'h23 : ((i == 0) ? 32'h37 : 32'h77);
            axw(OFS_CTRL, ctl, r);
            rd(OFS_CTRL, ctl, RESP_OKAY);
            src.strobe();
            wait_pulse(n);
            src.burst(na, nb, 22);
            src.strobe();
            wait_pulse(n);
            ex = pack(i != 1, (i == 1) ? 3 : ((i == 0) ? 4 : 8));
            chk("words", words, ex);
            chk("valid", 128'(valid), 128'h1);
            if (i == 0)
                chk("ch5 code1", 128'(words[35:32]), 128'h4);
            if (i == 0)
                chk("ch1 top", 128'(words[3:0]), 128'hf);
            @(posedge mclk_i);
            chk("pulse width", 128'(pulse), 128'h0);
            for (int k = 0; k < 4; k++)
                rd(OFS_WORD0 + 8'(4 * k), ex[32*k +: 32], RESP_OKAY);
        end
        src.strobe();
        wait_pulse(n);
        chk("cleared words", words, 128'h0);
        axw(OFS_PERIOD, 32'ha, r);
        axw(OFS_CTRL, 32'h34, r);
        wait_pulse(n);
        wait_pulse(n);
        chk("timer spacing", 128'(n), 128'ha);
        conclude();
    end
endmodule : test_spike_class_count_packer
